// File: hw/motion_defs.svh
`ifndef MOTION_DEFS_SVH
`define MOTION_DEFS_SVH
// How it works
// - Fixed part identifier readable at address zero.
// - Silicon revision code readable at address one.
// - Status bit 7 shows pending motion.
// - Status bit 4 shows accumulator overflow.
// - Status bit 0 shows resolution setting.
// - Status read freezes X and Y snapshot.
// - Controller reads both deltas before next status.
// - Wide accumulators saturate and flag overflow.
// - Overflow clears after delta read, not full.
// - Deltas report full scale; repeat until clear.
// - Controller allows 16 or 32 drain rounds.
// - Any write to 0x12 flushes motion.
// - X delta read returns count, then clears.
// - Y delta read returns count, then clears.
// - Controller reads status, X, Y in order.
// - Surface quality is upper eight feature bits.
// - Pixel total is upper byte of sum.
// - Peak pixel six bits, top two zero.
// - Registers reached only over serial port.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_PRODUCT   7'h00
`define ADDR_REVISION  7'h01
`define ADDR_STATUS    7'h02
`define ADDR_X         7'h03
`define ADDR_Y         7'h04
`define ADDR_QUALITY   7'h05
`define ADDR_PIXTOTAL  7'h06
`define ADDR_PEAK      7'h07
`define ADDR_FLUSH     7'h12

// ----------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------
`define MOT_BIT        3'd7
`define OVF_BIT        3'd4
`define RES_BIT        3'd0
`define ZERO_BYTE      8'h00
`define ACC_W          12
`define HALF_CYCLES    8'h04
`define GAP_CYCLES     8'h08
`define DRAIN_400      6'h10
`define DRAIN_800      6'h20
`endif

// File: hw/motion_pkg.sv
`include "motion_defs.svh"
package motion_pkg;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_ADDR = 2'b01,
    D_DATA = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_SHIFT  = 2'b01,
    H_GAP    = 2'b11,
    H_FINISH = 2'b10
  } host_state_t;

  typedef struct packed {
    logic                     cs_s1;
    logic                     cs_s2;
    logic                     sclk_s1;
    logic                     sclk_s2;
    logic                     sclk_d;
    logic                     mosi_s1;
    logic                     mosi_s2;
    dev_state_t               state;
    logic [2:0]               bitcnt;
    logic [6:0]               shreg;
    logic [6:0]               addr;
    logic                     is_write;
    logic [7:0]               tx;
    logic                     miso;
    logic                     miso_oe_n;
    logic signed [`ACC_W-1:0] acc_x;
    logic signed [`ACC_W-1:0] acc_y;
    logic [7:0]               dx;
    logic [7:0]               dy;
    logic                     ovf;
    logic [7:0]               quality;
    logic [7:0]               pixtotal;
    logic [7:0]               peak;
  } dev_reg_t;

  typedef struct packed {
    host_state_t state;
    logic [7:0]  cnt;
    logic [15:0] sh;
    logic [4:0]  bits;
    logic [7:0]  rx;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    logic        rep_act;
    logic [1:0]  rep_idx;
    logic [5:0]  rounds;
    logic [7:0]  status;
    logic [7:0]  x;
    logic [7:0]  y;
    logic        rep_done;
  } host_reg_t;
endpackage

// File: hw/serial_link.sv
`timescale 1ns/1ps
interface serial_link;
  logic CS_N;
  logic SCLK;
  logic MOSI;
  logic MISO_OUT;
  logic MISO_OE_N;
  logic MISO;

  // The data line floats when the sensor lets go; the pull-up makes it read high.
  assign MISO = MISO_OE_N ? 1'b1 : MISO_OUT;

  modport sensor (input CS_N, input SCLK, input MOSI, output MISO_OUT, output MISO_OE_N);
  modport controller (output CS_N, output SCLK, output MOSI, input MISO);
endinterface

// File: hw/motion_sensor_end.sv
`timescale 1ns/1ps
`include "motion_defs.svh"
module motion_sensor_end #(
  parameter logic [7:0] PRODUCT_CODE  = 8'h5a, // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'h01  // Arbitrary value.
) (
  input wire logic         MCLK,
  input wire logic         RESET,
  input wire logic         FRAME_VALID,
  input wire logic [7:0]   FRAME_DX,
  input wire logic [7:0]   FRAME_DY,
  input wire logic [9:0]   FEATURE_COUNT,
  input wire logic [15:0]  PIXEL_SUM,
  input wire logic [5:0]   PIXEL_PEAK,
  input wire logic         RESOLUTION,
  serial_link.sensor       LINK
);
  import motion_pkg::*;

  localparam int AW = `ACC_W;
  localparam logic signed [AW:0] ACC_MAX = (AW+1)'((1 << (AW-1)) - 1);
  localparam logic signed [AW:0] ACC_MIN = -(AW+1)'(1 << (AW-1));

  dev_reg_t r;
  dev_reg_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] clamp8(input logic signed [AW-1:0] a);
    if (a > $signed(AW'(127))) begin
      return 8'h7f;
    end else if (a < -$signed(AW'(128))) begin
      return 8'h80;
    end
    return a[7:0];
  endfunction

  function automatic logic signed [AW:0] widen(input logic signed [AW-1:0] a);
    return {a[AW-1], a};
  endfunction

  function automatic logic signed [AW:0] widen8(input logic [7:0] a);
    return {{(AW-7){a[7]}}, a};
  endfunction

  function automatic logic at_full(input logic signed [AW-1:0] a);
    return (widen(a) == ACC_MAX) || (widen(a) == ACC_MIN);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]        rd_byte;
    logic [7:0]        st;
    logic [7:0]        snap_x;
    logic [7:0]        snap_y;
    logic signed [AW:0] sx;
    logic signed [AW:0] sy;
    logic              rise;
    logic              rd_status;
    logic              rd_x;
    logic              rd_y;
    logic              flush;
    logic              sat;
    rd_byte   = `ZERO_BYTE;
    st        = `ZERO_BYTE;
    snap_x    = clamp8(r.acc_x);
    snap_y    = clamp8(r.acc_y);
    sx        = '0;
    sy        = '0;
    rise      = r.sclk_s2 & ~r.sclk_d;
    rd_status = 1'b0;
    rd_x      = 1'b0;
    rd_y      = 1'b0;
    flush     = 1'b0;
    sat       = 1'b0;
    n         = r;
    // Only the second stage of each synchroniser is looked at.
    n.cs_s1   = LINK.CS_N;
    n.cs_s2   = r.cs_s1;
    n.sclk_s1 = LINK.SCLK;
    n.sclk_s2 = r.sclk_s1;
    n.sclk_d  = r.sclk_s2;
    n.mosi_s1 = LINK.MOSI;
    n.mosi_s2 = r.mosi_s1;

    st[`MOT_BIT] = (r.acc_x != '0) || (r.acc_y != '0);
    st[`OVF_BIT] = r.ovf;
    st[`RES_BIT] = RESOLUTION;

    // Raising chip select aborts a transfer but leaves the registers alone.
    if (r.cs_s2) begin
      n.state     = D_IDLE;
      n.bitcnt    = 3'd0;
      n.miso_oe_n = 1'b1;
    end else begin
      n.miso_oe_n = 1'b0;
      case (r.state)
        D_IDLE: begin
          n.state  = D_ADDR;
          n.bitcnt = 3'd0;
        end
        D_ADDR: begin
          if (rise) begin
            n.shreg  = {r.shreg[5:0], r.mosi_s2};
            n.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == 3'd7) begin
              n.state    = D_DATA;
              n.bitcnt   = 3'd0;
              n.is_write = r.shreg[6];
              n.addr     = {r.shreg[5:0], r.mosi_s2};
              if (!r.shreg[6]) begin
                if (n.addr == `ADDR_PRODUCT) begin
                  rd_byte = PRODUCT_CODE;
                end else if (n.addr == `ADDR_REVISION) begin
                  rd_byte = REVISION_CODE;
                end else if (n.addr == `ADDR_STATUS) begin
                  rd_byte   = st;
                  rd_status = 1'b1;
                end else if (n.addr == `ADDR_X) begin
                  rd_byte = r.dx;
                  rd_x    = 1'b1;
                end else if (n.addr == `ADDR_Y) begin
                  rd_byte = r.dy;
                  rd_y    = 1'b1;
                end else if (n.addr == `ADDR_QUALITY) begin
                  rd_byte = r.quality;
                end else if (n.addr == `ADDR_PIXTOTAL) begin
                  rd_byte = r.pixtotal;
                end else if (n.addr == `ADDR_PEAK) begin
                  rd_byte = r.peak;
                end else begin
                  rd_byte = `ZERO_BYTE;
                end
                n.tx   = rd_byte;
                n.miso = rd_byte[7];
              end
            end
          end
        end
        D_DATA: begin
          if (rise) begin
            n.shreg  = {r.shreg[5:0], r.mosi_s2};
            n.tx     = {r.tx[6:0], 1'b0};
            n.miso   = r.tx[6];
            n.bitcnt = r.bitcnt + 3'd1;
            if (r.bitcnt == 3'd7) begin
              n.state  = D_ADDR;
              n.bitcnt = 3'd0;
              // Writes elsewhere in this set are dropped without effect.
              flush = r.is_write && (r.addr == `ADDR_FLUSH);
            end
          end
        end
        default: begin
          n.state = D_IDLE;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Motion accumulation
    // ----------------------------------------------------------------
    sx = widen(r.acc_x) - (rd_status ? widen8(snap_x) : '0);
    sy = widen(r.acc_y) - (rd_status ? widen8(snap_y) : '0);
    if (flush) begin
      sx = '0;
      sy = '0;
    end
    if (FRAME_VALID) begin
      sx = sx + widen8(FRAME_DX);
      sy = sy + widen8(FRAME_DY);
    end
    // Saturating keeps the sign of a runaway path even though its size is lost.
    if (sx > ACC_MAX) begin
      sx  = ACC_MAX;
      sat = 1'b1;
    end else if (sx < ACC_MIN) begin
      sx  = ACC_MIN;
      sat = 1'b1;
    end
    if (sy > ACC_MAX) begin
      sy  = ACC_MAX;
      sat = 1'b1;
    end else if (sy < ACC_MIN) begin
      sy  = ACC_MIN;
      sat = 1'b1;
    end
    n.acc_x = sx[AW-1:0];
    n.acc_y = sy[AW-1:0];

    if (rd_status) begin
      n.dx = snap_x;
      n.dy = snap_y;
    end
    if (rd_x || flush) begin
      n.dx = `ZERO_BYTE;
    end
    if (rd_y || flush) begin
      n.dy = `ZERO_BYTE;
    end

    if (flush || ((rd_x || rd_y) && !at_full(r.acc_x) && !at_full(r.acc_y))) begin
      n.ovf = 1'b0;
    end
    if (sat) begin
      n.ovf = 1'b1;
    end

    // ----------------------------------------------------------------
    // Frame statistics
    // ----------------------------------------------------------------
    if (FRAME_VALID) begin
      n.quality  = FEATURE_COUNT[9:2];
      n.pixtotal = PIXEL_SUM[15:8];
      n.peak     = {2'b00, PIXEL_PEAK};
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      r           <= '0;
      r.cs_s1     <= 1'b1;
      r.cs_s2     <= 1'b1;
      // The serial clock idles high, so the edge detector starts high to avoid a false rise.
      r.sclk_s1   <= 1'b1;
      r.sclk_s2   <= 1'b1;
      r.sclk_d    <= 1'b1;
      r.miso_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign LINK.MISO_OUT  = r.miso;
  assign LINK.MISO_OE_N = r.miso_oe_n;
endmodule

// File: hw/motion_controller_end.sv
`timescale 1ns/1ps
`include "motion_defs.svh"
module motion_controller_end #(
  parameter logic [7:0] HALF = `HALF_CYCLES,
  parameter logic [7:0] GAP  = `GAP_CYCLES
) (
  input wire logic         MCLK,
  input wire logic         RESET,
  input wire logic         REQ,
  input wire logic         REQ_WRITE,
  input wire logic [6:0]   REQ_ADDR,
  input wire logic [7:0]   REQ_WDATA,
  input wire logic         REPORT,
  output logic             BUSY,
  output logic             DONE,
  output logic [7:0]       RDATA,
  output logic             REPORT_DONE,
  output logic [7:0]       REPORT_STATUS,
  output logic [7:0]       REPORT_X,
  output logic [7:0]       REPORT_Y,
  serial_link.controller   LINK
);
  import motion_pkg::*;

  host_reg_t r;
  host_reg_t n;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] raddr;
    logic [5:0] limit;
    raddr      = `ADDR_STATUS + {5'd0, r.rep_idx};
    limit      = r.status[`RES_BIT] ? `DRAIN_800 : `DRAIN_400;
    n          = r;
    n.done     = 1'b0;
    n.rep_done = 1'b0;
    case (r.state)
      H_IDLE: begin
        // Chip select stays high for a while so the sensor sees the frame end.
        if (r.cnt != 8'd0) begin
          n.cnt  = r.cnt - 8'd1;
          n.busy = (r.cnt != 8'd1) || r.rep_act;
        end else if (r.rep_act || REPORT || REQ) begin
          n.state = H_SHIFT;
          n.busy  = 1'b1;
          n.cs_n  = 1'b0;
          n.sclk  = 1'b1;
          n.bits  = 5'd16;
          n.cnt   = HALF - 8'd1;
          if (r.rep_act || REPORT) begin
            n.rep_act = 1'b1;
            n.sh      = {1'b0, raddr, 8'h00};
            if (!r.rep_act) begin
              n.rep_idx = 2'd0;
              n.rounds  = 6'd0;
              n.sh      = {1'b0, `ADDR_STATUS, 8'h00};
            end
          end else begin
            n.sh = {REQ_WRITE, REQ_ADDR, REQ_WDATA};
          end
        end
      end
      H_SHIFT: begin
        if (r.cnt != 8'd0) begin
          n.cnt = r.cnt - 8'd1;
        end else begin
          n.cnt = HALF - 8'd1;
          if (r.sclk) begin
            n.sclk = 1'b0;
            n.mosi = r.sh[15];
            n.sh   = {r.sh[14:0], 1'b0};
          end else begin
            n.sclk = 1'b1;
            n.rx   = {r.rx[6:0], LINK.MISO};
            n.bits = r.bits - 5'd1;
            if (r.bits == 5'd9) begin
              n.state = H_GAP;
              n.cnt   = GAP;
            end else if (r.bits == 5'd1) begin
              n.state = H_FINISH;
            end
          end
        end
      end
      H_GAP: begin
        if (r.cnt != 8'd0) begin
          n.cnt = r.cnt - 8'd1;
        end else begin
          n.state = H_SHIFT;
          n.cnt   = HALF - 8'd1;
        end
      end
      H_FINISH: begin
        if (r.cnt != 8'd0) begin
          n.cnt = r.cnt - 8'd1;
        end else begin
          n.state = H_IDLE;
          n.cs_n  = 1'b1;
          n.cnt   = HALF;
          if (r.rep_act) begin
            n.rep_idx = r.rep_idx + 2'd1;
            if (r.rep_idx == 2'd0) begin
              n.status = r.rx;
            end else if (r.rep_idx == 2'd1) begin
              n.x = r.rx;
            end else begin
              // Both deltas are in before the next status read goes out.
              n.y       = r.rx;
              n.rep_idx = 2'd0;
              n.rounds  = r.rounds + 6'd1;
              if (!r.status[`MOT_BIT] || (r.rounds + 6'd1 >= limit)) begin
                n.rep_act  = 1'b0;
                n.rep_done = 1'b1;
              end
            end
          end else begin
            n.done  = 1'b1;
            n.rdata = r.rx;
          end
        end
      end
      default: begin
        n.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      r      <= '0;
      r.cs_n <= 1'b1;
      r.sclk <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign LINK.CS_N     = r.cs_n;
  assign LINK.SCLK     = r.sclk;
  assign LINK.MOSI     = r.mosi;
  assign BUSY          = r.busy;
  assign DONE          = r.done;
  assign RDATA         = r.rdata;
  assign REPORT_DONE   = r.rep_done;
  assign REPORT_STATUS = r.status;
  assign REPORT_X      = r.x;
  assign REPORT_Y      = r.y;
endmodule

// File: verif/motion_link_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial link checks
// ----------------------------------------------------------------
module motion_link_sva (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic MOSI,
  input wire logic MISO_OUT,
  input wire logic MISO_OE_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  logic [4:0] rises;

  // A short or long select window would slip the sensor's framing, so rises are counted.
  always_ff @(posedge MCLK) begin
    if (RESET || CS_N) begin
      rises <= 5'h00;
    end else if ($rose(SCLK)) begin
      rises <= rises + 5'h01;
    end
  end

  chk_idle_clock_high: assert property (CS_N |-> SCLK)
    else $error("Serial clock low while deselected.");
  chk_drive_on_select: assert property ($fell(CS_N) |-> ##[1:5] !MISO_OE_N)
    else $error("Data line not driven after select.");
  chk_release_on_deselect: assert property ($rose(CS_N) |-> ##[1:5] MISO_OE_N)
    else $error("Data line still driven after deselect.");
  chk_low_half_min: assert property ($fell(SCLK) |=> !SCLK [*3])
    else $error("Serial clock low phase too short.");
  chk_high_half_min: assert property ($rose(SCLK) |=> SCLK [*3])
    else $error("Serial clock high phase too short.");
  chk_mosi_on_fall: assert property (
    !CS_N && !$past(CS_N) && $changed(MOSI) |-> $fell(SCLK))
    else $error("Command line moved away from a falling clock.");
  chk_miso_steady_rise: assert property (
    $rose(SCLK) && !MISO_OE_N |-> $stable(MISO_OUT))
    else $error("Data line moved at a sampling edge.");
  chk_frame_sixteen: assert property ($rose(CS_N) |-> rises == 5'h10)
    else $error("Select window did not hold sixteen clocks.");
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
`include "motion_defs.svh"
module tb_top;
  localparam logic [7:0] PART_IDENTIFIER_BITS = 8'h3c; // Arbitrary value.
  localparam logic [7:0] REV = 8'h07; // Arbitrary value.
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        fv = 1'b0;
  logic [7:0]  fdx = 8'h00;
  logic [7:0]  fdy = 8'h00;
  logic [9:0]  fcnt = 10'h000;
  logic [15:0] psum = 16'h0000;
  logic [5:0]  ppk = 6'h00;
  logic        res = 1'b0;
  logic        req = 1'b0;
  logic        reqw = 1'b0;
  logic [6:0]  reqa = 7'h00;
  logic [7:0]  reqd = 8'h00;
  logic        rep = 1'b0;
  logic        busy;
  logic        done;
  logic        rdone;
  logic [7:0]  rdata;
  logic [7:0]  rep_s;
  logic [7:0]  rep_x;
  logic [7:0]  rep_y;
  logic [15:0] mo_sh;
  logic [15:0] mo_fr;
  logic [7:0]  mi_sh;
  logic [7:0]  mi_fr;
  int          miscompares = 0;
  int          n_tests = 0;

  serial_link lnk ();
  motion_sensor_end #(.PRODUCT_CODE(PART_IDENTIFIER_BITS), .REVISION_CODE(REV)) i_motion_sensor_end (
    .MCLK(mclk), .RESET(reset), .FRAME_VALID(fv), .FRAME_DX(fdx), .FRAME_DY(fdy),
    .FEATURE_COUNT(fcnt), .PIXEL_SUM(psum), .PIXEL_PEAK(ppk), .RESOLUTION(res), .LINK(lnk));
  motion_controller_end i_motion_controller_end (
    .MCLK(mclk), .RESET(reset), .REQ(req), .REQ_WRITE(reqw), .REQ_ADDR(reqa),
    .REQ_WDATA(reqd), .REPORT(rep), .BUSY(busy), .DONE(done), .RDATA(rdata),
    .REPORT_DONE(rdone), .REPORT_STATUS(rep_s), .REPORT_X(rep_x), .REPORT_Y(rep_y),
    .LINK(lnk));
  motion_link_sva i_motion_link_sva (
    .MCLK(mclk), .RESET(reset), .CS_N(lnk.CS_N), .SCLK(lnk.SCLK), .MOSI(lnk.MOSI),
    .MISO_OUT(lnk.MISO_OUT), .MISO_OE_N(lnk.MISO_OE_N));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Wire monitor and tasks
  // ----------------------------------------------------------------
  always @(posedge lnk.SCLK) begin
    if (!lnk.CS_N) begin
      mo_sh <= {mo_sh[14:0], lnk.MOSI};
      mi_sh <= {mi_sh[6:0], lnk.MISO};
    end
  end
  always @(posedge lnk.CS_N) begin
    mo_fr <= mo_sh;
    mi_fr <= mi_sh;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request is held until BUSY rises, since one given in recovery is dropped.
  task automatic xfer(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d);
    int k;
    @(negedge mclk);
    rep = r;
    req = !r;
    reqw = w;
    reqa = a;
    reqd = d;
    for (k = 0; k < 40000 && (r ? rdone : done) !== 1'b1; k++) begin
      @(negedge mclk);
      req = req && busy !== 1'b1;
      rep = rep && busy !== 1'b1;
    end
    if (k >= 40000) begin
      miscompares++;
      $display("[FAIL] transfer end expected 1 seen 0");
    end
    for (k = 0; k < 50 && busy === 1'b1; k++) @(negedge mclk);
  endtask

  task automatic rd(input string n, input logic [6:0] a, input logic [7:0] e);
    xfer(1'b0, 1'b0, a, 8'h00);
    chk(n, e, rdata);
  endtask

  task automatic frame(input logic [7:0] x, input logic [7:0] y, input int n);
    @(negedge mclk);
    fdx = x;
    fdy = y;
    fv = 1'b1;
    repeat (n) @(negedge mclk);
    fv = 1'b0;
  endtask

  task automatic stat(input logic [9:0] c, input logic [15:0] s, input logic [5:0] p);
    fcnt = c;
    psum = s;
    ppk = p;
    frame(8'h00, 8'h00, 1);
    rd("quality", `ADDR_QUALITY, c[9:2]);
    rd("pixel total", `ADDR_PIXTOTAL, s[15:8]);
    rd("peak", `ADDR_PEAK, {2'b00, p});
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    rd("product", `ADDR_PRODUCT, PART_IDENTIFIER_BITS);
    chk("miso byte", PART_IDENTIFIER_BITS, mi_fr);
    rd("revision", `ADDR_REVISION, REV);
    xfer(1'b0, 1'b1, `ADDR_PRODUCT, 8'hff);
    rd("product kept", `ADDR_PRODUCT, PART_IDENTIFIER_BITS);
    xfer(1'b0, 1'b1, 7'h08, 8'hff);
    rd("reserved 08", 7'h08, 8'h00);
    rd("reserved 09", 7'h09, 8'h00);
    chk("read addr byte", 8'h09, mo_fr[15:8]);
    $display("test identity done");
    stat(10'h2a7, 16'hdd12, 6'h3f);
    stat(10'h155, 16'h1234, 6'h2a);
    $display("test statistics done");
    rd("status idle", `ADDR_STATUS, 8'h00);
    res = 1'b1;
    rd("status 800", `ADDR_STATUS, 8'h01);
    res = 1'b0;
    frame(8'h05, 8'hfd, 1);
    rd("status motion", `ADDR_STATUS, 8'h80);
    frame(8'h07, 8'h00, 1);
    rd("x frozen", `ADDR_X, 8'h05);
    rd("y frozen", `ADDR_Y, 8'hfd);
    rd("x cleared", `ADDR_X, 8'h00);
    rd("y cleared", `ADDR_Y, 8'h00);
    rd("status rest", `ADDR_STATUS, 8'h80);
    rd("x rest", `ADDR_X, 8'h07);
    rd("y rest", `ADDR_Y, 8'h00);
    rd("status empty", `ADDR_STATUS, 8'h00);
    frame(8'h03, 8'h00, 1);
    rd("status first", `ADDR_STATUS, 8'h80);
    frame(8'h04, 8'h00, 1);
    rd("status second", `ADDR_STATUS, 8'h80);
    rd("x replaced", `ADDR_X, 8'h04);
    $display("test snapshot done");
    frame(8'h7f, 8'h80, 20);
    rd("status overflow", `ADDR_STATUS, 8'h90);
    rd("x full scale", `ADDR_X, 8'h7f);
    rd("y full scale", `ADDR_Y, 8'h80);
    xfer(1'b1, 1'b0, 7'h00, 8'h00);
    chk("report order", 8'h04, mo_fr[15:8]);
    chk("report status", 8'h80, rep_s);
    chk("report x", 8'h0f, rep_x);
    chk("report y", 8'h00, rep_y);
    rd("status drained", `ADDR_STATUS, 8'h00);
    $display("test overflow done");
    frame(8'h7f, 8'h7f, 20);
    rd("status full", `ADDR_STATUS, 8'h90);
    xfer(1'b0, 1'b1, `ADDR_FLUSH, 8'h5a);
    chk("write addr byte", 8'h92, mo_fr[15:8]);
    chk("write data byte", 8'h5a, mo_fr[7:0]);
    rd("x flushed", `ADDR_X, 8'h00);
    rd("status flushed", `ADDR_STATUS, 8'h00);
    $display("test flush done");
    res = 1'b1;
    frame(8'h7f, 8'h7f, 20);
    xfer(1'b1, 1'b0, 7'h00, 8'h00);
    chk("report 800 status", 8'h01, rep_s);
    chk("report 800 x", 8'h00, rep_x);
    chk("report 800 y", 8'h00, rep_y);
    $display("test drain 800 done");
    end_sim();
  end
endmodule
